/* hdl/scrx_pkg.sv */
package scrx_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_RXD  = 8'h0C;
    localparam logic [7:0] ADDR_TXD  = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int MD_CARD = 0; // smart-card mode
    localparam int MD_GM   = 1; // clock_output_mode_bit
    localparam int MD_ODD  = 2; // odd parity
    localparam int CT_TE   = 0; // transmit_enable
    localparam int CT_RE   = 1; // receive_enable
    localparam int CT_RIE  = 2; // receive_irq_enable
    localparam int CT_TIE  = 3; // transmit irq enable
    localparam int CT_TRANSMIT_END_IRQ_ENABLE = 4; // transmit_end_irq_enable
    localparam int CT_CLOCK_OUTPUT_ENABLE = 5; // clock_output_enable
    localparam int CT_CLOCK_LEVEL_SELECT = 6; // clock_level_select
    localparam int FL_TRANSMIT_EMPTY_FLAG = 0; // transmit_empty_flag
    localparam int FL_RECEIVE_FULL_FLAG = 1; // receive_full_flag
    localparam int FL_OVERRUN_FLAG = 2; // overrun_flag
    localparam int FL_FER  = 3; // framing_error_flag
    localparam int FL_PER  = 4; // parity_error_flag
    localparam int FL_TRANSMIT_END_FLAG = 5; // transmit_end_flag
    localparam int FL_ERS  = 6; // error_signal_flag

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [2:0]  MODE_RST = 3'h0;
    localparam logic [6:0]  CTRL_RST = 7'h00;
    localparam logic [6:0]  FLAG_RST = 7'h21;
    localparam logic [11:0] ETU_CYC  = 12'h020;
    localparam logic [11:0] ETU_HALF = 12'h010;
    localparam logic [7:0]  SCK_HALF = 8'h04;
    localparam logic [3:0]  BIT_PAR  = 4'h9;
    localparam logic [3:0]  BIT_END  = 4'hA;

    // receiver states
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b10,
        RX_ERR   = 2'b11
    } scrx_rx_state_type;

    // whole block state
    typedef struct packed {
        logic              ack;
        logic [7:0]        rdat;
        logic [2:0]        mode;
        logic [6:0]        ctrl;
        logic [6:0]        flg;
        logic [7:0]        rxd;
        logic [7:0]        txd;
        logic [7:0]        sh;
        logic              parb;
        scrx_rx_state_type rxs;
        logic [3:0]        bitn;
        logic [11:0]       cnt;
        logic [2:0]        sync;
        logic              sd_oe;
        logic              sck;
        logic              sck_run;
        logic [7:0]        ck_cnt;
        logic              receive_full_irq;
        logic              transmit_empty_irq;
        logic              receive_error_irq;
        logic              transmit_end_irq;
    } scrx_state_type;

endpackage

/* hdl/scrx_top.sv */
`timescale 1ns/1ps
module scrx_top (
    // clock, reset, enable
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // serial data line, open drain
    input  wire logic        i_sd,
    output logic             o_sd_out,
    output logic             o_sd_oe,
    // serial clock pin
    output logic             o_sck,
    // transmit engine events
    input  wire logic        i_tx_taken,
    input  wire logic        i_tx_done,
    input  wire logic        i_tx_retry,
    input  wire logic        i_err_sig,
    output logic      [7:0]  o_tx_data,
    // transfer controller acks
    input  wire logic        i_dtc_rx_ack,
    input  wire logic        i_dtc_tx_ack,
    // interrupt requests
    output logic             o_rxi,
    output logic             o_txi,
    output logic             o_eri,
    output logic             o_tei
);

    // ****************************************
    // state registers
    // ****************************************
    scrx_pkg::scrx_state_type st_reg;  // present
    scrx_pkg::scrx_state_type st_next; // next

    // ****************************************
    // next-state logic
    // ****************************************
    // all decisions in one place; set wins
    // over clear because sets come last
    always_comb begin
        logic       req;
        logic       wr;
        logic       card;
        logic       lvl;
        logic       perr;
        logic       ferr;
        logic       ovr;
        logic [6:0] f;
        req  = 1'b0;
        wr   = 1'b0;
        card = 1'b0;
        lvl  = 1'b0;
        perr = 1'b0;
        ferr = 1'b0;
        ovr  = 1'b0;
        f    = st_reg.flg;
        st_next = st_reg;

        card = st_reg.mode[scrx_pkg::MD_CARD];
        lvl  = st_reg.ctrl[scrx_pkg::CT_CLOCK_LEVEL_SELECT];

        // pin synchroniser, oldest stage last
        st_next.sync = {st_reg.sync[1:0], i_sd};

        // ------------------------------------
        // bus slave: ack one cycle after req
        // ------------------------------------
        req = i_wb_cyc & i_wb_stb;
        st_next.ack = req & ~st_reg.ack;
        // write only on the acked cycle
        wr = req & i_wb_we & st_reg.ack
             & i_wb_sel[0];

        // read data mux
        if (i_wb_adr == scrx_pkg::ADDR_MODE) begin
            st_next.rdat = {5'h00, st_reg.mode};
        end else if (i_wb_adr
                     == scrx_pkg::ADDR_CTRL) begin
            st_next.rdat = {1'b0, st_reg.ctrl};
        end else if (i_wb_adr
                     == scrx_pkg::ADDR_STAT) begin
            st_next.rdat = {1'b0, st_reg.flg};
        end else if (i_wb_adr
                     == scrx_pkg::ADDR_RXD) begin
            st_next.rdat = st_reg.rxd;
        end else if (i_wb_adr
                     == scrx_pkg::ADDR_TXD) begin
            st_next.rdat = st_reg.txd;
        end else begin
            // unmapped reads as zero
            st_next.rdat = 8'h00;
        end

        // register writes
        if (wr) begin
            if (i_wb_adr == scrx_pkg::ADDR_MODE) begin
                st_next.mode = i_wb_dat[2:0];
            end else if (i_wb_adr
                         == scrx_pkg::ADDR_CTRL) begin
                st_next.ctrl = i_wb_dat[6:0];
            end else if (i_wb_adr
                         == scrx_pkg::ADDR_STAT) begin
                // writing 0 clears, 1 keeps
                f = f & i_wb_dat[6:0];
            end else if (i_wb_adr
                         == scrx_pkg::ADDR_TXD) begin
                st_next.txd = i_wb_dat[7:0];
                f[scrx_pkg::FL_TRANSMIT_EMPTY_FLAG] = 1'b0;
                if (card) begin
                    f[scrx_pkg::FL_TRANSMIT_END_FLAG] = 1'b0;
                end
            end
        end

        // ------------------------------------
        // automatic clears by the controller
        // ------------------------------------
        // read clears full
        if (i_dtc_rx_ack) begin
            f[scrx_pkg::FL_RECEIVE_FULL_FLAG] = 1'b0;
        end
        if (i_dtc_tx_ack) begin
            f[scrx_pkg::FL_TRANSMIT_EMPTY_FLAG] = 1'b0;
            if (card) begin
                f[scrx_pkg::FL_TRANSMIT_END_FLAG] = 1'b0;
            end
        end

        // ------------------------------------
        // transmit engine events
        // ------------------------------------
        // shift register loaded, data free
        if (i_tx_taken && !card) begin
            f[scrx_pkg::FL_TRANSMIT_EMPTY_FLAG] = 1'b1;
        end
        if (i_tx_done && !i_tx_retry) begin
            f[scrx_pkg::FL_TRANSMIT_END_FLAG] = 1'b1;
            if (card) begin
                f[scrx_pkg::FL_TRANSMIT_EMPTY_FLAG] = 1'b1;
            end
        end
        if (i_err_sig && card) begin
            f[scrx_pkg::FL_ERS] = 1'b1;
        end

        // ------------------------------------
        // receiver
        // ------------------------------------
        case (st_reg.rxs)
            scrx_pkg::RX_IDLE: begin
                st_next.cnt  = 12'h000;
                st_next.bitn = 4'h0;
                // falling edge on the line
                if (st_reg.ctrl[scrx_pkg::CT_RE]
                    && st_reg.sync[2]
                    && !st_reg.sync[1]) begin
                    st_next.rxs = scrx_pkg::RX_START;
                end
            end
            scrx_pkg::RX_START: begin
                // confirm start at its middle
                if (st_reg.cnt
                    == scrx_pkg::ETU_HALF - 12'h001)
                begin
                    st_next.cnt = 12'h000;
                    if (!st_reg.sync[1]) begin
                        st_next.bitn = 4'h1;
                        st_next.rxs  = scrx_pkg::RX_BITS;
                    end else begin
                        // glitch, back to idle
                        st_next.rxs = scrx_pkg::RX_IDLE;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 12'h001;
                end
            end
            scrx_pkg::RX_BITS: begin
                if (st_reg.cnt
                    == scrx_pkg::ETU_CYC - 12'h001)
                begin
                    st_next.cnt  = 12'h000;
                    st_next.bitn = st_reg.bitn + 4'h1;
                    if (st_reg.bitn < scrx_pkg::BIT_PAR)
                    begin
                        // data bits, lsb first
                        st_next.sh = {st_reg.sync[1],
                                      st_reg.sh[7:1]};
                    end else if (st_reg.bitn
                                 == scrx_pkg::BIT_PAR)
                    begin
                        st_next.parb = st_reg.sync[1];
                    end else begin
                        // end of frame, 10.5 units in
                        perr = ^{st_reg.sh, st_reg.parb,
                                 st_reg.mode[
                                     scrx_pkg::MD_ODD]};
                        // stop bit only outside card
                        ferr = ~card & ~st_reg.sync[1];
                        ovr  = st_reg.flg[
                                   scrx_pkg::FL_RECEIVE_FULL_FLAG];
                        if (ovr) begin
                            // old data kept on overrun
                            f[scrx_pkg::FL_OVERRUN_FLAG] = 1'b1;
                        end else begin
                            st_next.rxd = st_reg.sh;
                        end
                        if (perr) begin
                            f[scrx_pkg::FL_PER] = 1'b1;
                        end
                        if (ferr) begin
                            f[scrx_pkg::FL_FER] = 1'b1;
                        end
                        if (!perr && !ferr && !ovr) begin
                            f[scrx_pkg::FL_RECEIVE_FULL_FLAG] = 1'b1;
                        end
                        if (card && perr) begin
                            st_next.sd_oe = 1'b1;
                            st_next.rxs = scrx_pkg::RX_ERR;
                        end else begin
                            st_next.rxs =
                                scrx_pkg::RX_IDLE;
                        end
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 12'h001;
                end
            end
            scrx_pkg::RX_ERR: begin
                if (st_reg.cnt
                    == scrx_pkg::ETU_CYC - 12'h001)
                begin
                    st_next.cnt   = 12'h000;
                    st_next.sd_oe = 1'b0;
                    st_next.rxs   = scrx_pkg::RX_IDLE;
                end else begin
                    st_next.cnt = st_reg.cnt + 12'h001;
                end
            end
            default: begin
                st_next.rxs = scrx_pkg::RX_IDLE;
            end
        endcase

        // receiver off: abandon frame, free line
        if (!st_reg.ctrl[scrx_pkg::CT_RE]) begin
            st_next.rxs   = scrx_pkg::RX_IDLE;
            st_next.sd_oe = 1'b0;
        end

        st_next.flg = f;

        // ------------------------------------
        // clock output
        // ------------------------------------
        if (!st_reg.sck_run) begin
            // parked at the selected level
            st_next.sck    = lvl;
            st_next.ck_cnt = 8'h00;
            if (st_reg.ctrl[scrx_pkg::CT_CLOCK_OUTPUT_ENABLE]) begin
                st_next.sck_run = 1'b1;
            end
        end else if (!st_reg.ctrl[scrx_pkg::CT_CLOCK_OUTPUT_ENABLE]
                     && !st_reg.mode[scrx_pkg::MD_GM])
        begin
            // without the mode bit stop at once
            st_next.sck_run = 1'b0;
            st_next.sck     = lvl;
        end else if (st_reg.ck_cnt
                     == scrx_pkg::SCK_HALF - 8'h01) begin
            st_next.ck_cnt = 8'h00;
            if (!st_reg.ctrl[scrx_pkg::CT_CLOCK_OUTPUT_ENABLE]) begin
                st_next.sck     = lvl;
                st_next.sck_run = 1'b0;
            end else begin
                st_next.sck = ~st_reg.sck;
            end
        end else begin
            st_next.ck_cnt = st_reg.ck_cnt + 8'h01;
        end

        // ------------------------------------
        // interrupt requests
        // ------------------------------------
        // full irq when enabled
        st_next.receive_full_irq = f[scrx_pkg::FL_RECEIVE_FULL_FLAG]
                      & st_reg.ctrl[scrx_pkg::CT_RIE];
        st_next.receive_error_irq = st_reg.ctrl[scrx_pkg::CT_RIE]
                      & (f[scrx_pkg::FL_OVERRUN_FLAG]
                         | f[scrx_pkg::FL_PER]
                         | (card ? f[scrx_pkg::FL_ERS]
                                 : f[scrx_pkg::FL_FER]));
        st_next.transmit_empty_irq = st_reg.ctrl[scrx_pkg::CT_TIE]
                      & (card ? f[scrx_pkg::FL_TRANSMIT_END_FLAG]
                              : f[scrx_pkg::FL_TRANSMIT_EMPTY_FLAG]);
        st_next.transmit_end_irq = ~card & ~st_next.transmit_empty_irq
                      & f[scrx_pkg::FL_TRANSMIT_END_FLAG]
                      & st_reg.ctrl[scrx_pkg::CT_TRANSMIT_END_IRQ_ENABLE];
    end

    // ****************************************
    // state register
    // ****************************************
    // clock enable low freezes everything
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n) begin
            st_reg         <= '0;
            st_reg.mode    <= scrx_pkg::MODE_RST;
            st_reg.ctrl    <= scrx_pkg::CTRL_RST;
            st_reg.flg     <= scrx_pkg::FLAG_RST;
            st_reg.sync    <= 3'h7;
            st_reg.rxs     <= scrx_pkg::RX_IDLE;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs, all from flops except the constant o_sd_out
    // ****************************************
    assign o_wb_dat  = {24'h000000, st_reg.rdat};
    assign o_wb_ack  = st_reg.ack;
    // line only ever pulled low
    assign o_sd_out  = 1'b0;
    assign o_sd_oe   = st_reg.sd_oe;
    assign o_sck     = st_reg.sck;
    assign o_tx_data = st_reg.txd;
    assign o_rxi     = st_reg.receive_full_irq;
    assign o_txi     = st_reg.transmit_empty_irq;
    assign o_eri     = st_reg.receive_error_irq;
    assign o_tei     = st_reg.transmit_end_irq;

endmodule // scrx_top

/* bench/scrx_checker.sv */
`timescale 1ns/1ps
module scrx_checker (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // register bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic o_wb_ack,
    // pins and transfer acks
    input wire logic o_sd_oe,
    input wire logic o_sck,
    input wire logic i_dtc_rx_ack,
    input wire logic i_dtc_tx_ack,
    // requests
    input wire logic o_rxi,
    input wire logic o_txi,
    input wire logic o_eri,
    input wire logic o_tei
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    // ****************************************
    // width counters
    // ****************************************
    logic [7:0] oe_cnt; // cycles error pulse high
    logic [7:0] hi_cnt; // cycles clock high
    logic [7:0] lo_cnt; // cycles clock low

    // saturating, so long parks never wrap
    function automatic logic [7:0] sat(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    // count length of each level
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            oe_cnt <= 8'h00;
            hi_cnt <= 8'h00;
            lo_cnt <= 8'h00;
        end else begin
            oe_cnt <= o_sd_oe ? sat(oe_cnt) : 8'h00;
            hi_cnt <= o_sck ? sat(hi_cnt) : 8'h00;
            lo_cnt <= o_sck ? 8'h00 : sat(lo_cnt);
        end
    end

    // ****************************************
    // bus handshake steps
    // ****************************************
    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack_once;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    AST_ACK_LAT: assert property ($rose(i_wb_cyc && i_wb_stb) |->
        s_req ##1 s_ack_once) else $error("bus ack timing wrong");
    AST_OE_WIDTH: assert property ($fell(o_sd_oe) |-> oe_cnt == 8'h20)
        else $error("error pulse not one unit");
    AST_ERR_NO_FULL: assert property ($rose(o_sd_oe) |-> !$rose(o_rxi)[*3])
        else $error("full request on bad frame");
    AST_RX_ACK_CLR: assert property (i_dtc_rx_ack |=> !o_rxi)
        else $error("full request kept after read");
    AST_TX_ACK_CLR: assert property (i_dtc_tx_ack |=> !o_txi)
        else $error("empty request kept after write");
    AST_TEI_PRIO: assert property (o_tei |-> !o_txi)
        else $error("end request beside empty request");
    AST_SCK_HI: assert property ($fell(o_sck) |-> hi_cnt >= 8'h04)
        else $error("clock high pulse too short");
    AST_SCK_LO: assert property ($rose(o_sck) |-> lo_cnt >= 8'h04)
        else $error("clock low pulse too short");
    AST_ERI_HOLD: assert property ($fell(o_eri) |->
        $past(o_wb_ack && i_wb_we)) else $error("error request fell alone");
endmodule // scrx_checker

/* bench/scrx_card_model.sv */
`timescale 1ns/1ps
module scrx_card_model #(
    parameter int ETU = 32 // bit time in system cycles
) (
    // clock
    input  wire logic       i_ref_clk,
    // frame request
    input  wire logic       i_go,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_bad_par,
    // shared data line
    input  wire logic       i_line,
    output logic            o_low,
    // status
    output logic            o_busy,
    output logic            o_err_seen
);
    logic [8:0] frame; // data then parity, lsb first

    initial begin
        o_low = 1'b0;
        o_busy = 1'b0;
        o_err_seen = 1'b0;
    end

    // one frame per request; released line is pulled high
    always @(posedge i_ref_clk) begin
        if (i_go) begin
            frame = {^i_byte ^ i_bad_par, i_byte};
            o_busy <= 1'b1;
            o_err_seen <= 1'b0;
            o_low <= 1'b1;
            repeat (ETU) @(posedge i_ref_clk);
            for (int k = 0; k < 9; k++) begin
                o_low <= ~frame[k];
                repeat (ETU) @(posedge i_ref_clk);
            end
            o_low <= 1'b0;
            repeat (ETU * 3 / 4) @(posedge i_ref_clk);
            o_err_seen <= ~i_line;
            repeat (ETU * 3 / 2) @(posedge i_ref_clk);
            o_busy <= 1'b0;
        end
    end
endmodule // scrx_card_model

/* bench/scrx_top_tb.sv */
`timescale 1ns/1ps
module scrx_top_tb;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [7:0] A_MODE = scrx_pkg::ADDR_MODE;
    localparam logic [7:0] A_CTRL = scrx_pkg::ADDR_CTRL;
    localparam logic [7:0] A_STAT = scrx_pkg::ADDR_STAT;
    localparam logic [7:0] A_RXD  = scrx_pkg::ADDR_RXD;
    localparam logic [7:0] A_TXD  = scrx_pkg::ADDR_TXD;
    // event bits: taken done retry err rxack txack
    localparam logic [5:0] E_TK = 6'h01, E_DN = 6'h02, E_RT = 6'h04;
    localparam logic [5:0] E_ER = 6'h08, E_RA = 6'h10, E_TA = 6'h20;
    logic        i_ref_clk = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [5:0]  ev = 6'h00; // transmit and controller events
    logic        go = 1'b0, cbad = 1'b0;
    logic [7:0]  cbyte = 8'h00;
    logic        card_low, busy, err_seen, o_sd_oe, o_sck, o_wb_ack;
    logic        o_sd_out, ce = 1'b1; // driven level, clock enable
    logic        o_rxi, o_txi, o_eri, o_tei;
    logic [31:0] o_wb_dat;
    logic [7:0]  o_tx_data;
    int          failures = 0, n_tests = 0, t;
    // open drain with pull-up: the block pulls only with its own level
    wire         line = ~card_low & (o_sd_oe ? o_sd_out : 1'b1);
    wire [3:0]   irqs = {o_rxi, o_txi, o_eri, o_tei};

    always #4 i_ref_clk = ~i_ref_clk;

    scrx_top scrx_top_inst (.i_ref_clk, .i_arst_n, .i_ce(ce),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat, .o_wb_ack,
        .i_sd(line), .o_sd_out, .o_sd_oe, .o_sck,
        .i_tx_taken(ev[0]), .i_tx_done(ev[1]), .i_tx_retry(ev[2]),
        .i_err_sig(ev[3]), .o_tx_data, .i_dtc_rx_ack(ev[4]),
        .i_dtc_tx_ack(ev[5]), .o_rxi, .o_txi, .o_eri, .o_tei);
    scrx_card_model #(.ETU(int'(scrx_pkg::ETU_CYC))) scrx_card_model_inst (
        .i_ref_clk, .i_go(go), .i_byte(cbyte), .i_bad_par(cbad),
        .i_line(line), .o_low(card_low), .o_busy(busy),
        .o_err_seen(err_seen));

    // ****************************************
    // tasks
    // ****************************************
    task automatic tally_and_finish(input bit hung);
        if (hung) failures++;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            tick(1);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 16);
        q = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 16) tally_and_finish(1'b1);
        tick(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(a, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask
    // one-cycle event pulse, then let requests settle
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        tick(1);
        ev <= 6'h00;
        tick(2);
    endtask
    task automatic send(input logic [7:0] b, input logic bad);
        int k;
        k = 0;
        go <= 1'b1;
        cbyte <= b;
        cbad <= bad;
        tick(1);
        go <= 1'b0;
        tick(1);
        while (busy === 1'b1 && k < 600) begin
            tick(1);
            k++;
        end
        if (k >= 600) tally_and_finish(1'b1);
        tick(2);
    endtask
    task automatic toggles(input int n, output int c);
        logic last;
        c = 0;
        last = o_sck;
        repeat (n) begin
            tick(1);
            if (o_sck !== last) c++;
            last = o_sck;
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        tick(2);
        i_arst_n <= 1'b1;
        tick(1);
        rd(A_STAT, 32'h21);
        rd(A_CTRL, 32'h00);
        rd(8'h14, 32'h00); // unmapped place reads zero
        $display("reset values done");
        wr(A_CTRL, 8'h40);
        tick(1); // parked level follows the write by one edge
        chk(o_sck, 1'b1);
        wr(A_MODE, 8'h03);
        wr(A_CTRL, 8'h60);
        toggles(64, t);
        chk(32'(t >= 14 && t <= 17), 32'h1);
        wr(A_CTRL, 8'h40);
        tick(8);
        toggles(32, t);
        chk(t, 32'h0);
        chk(o_sck, 1'b1);
        wr(A_CTRL, 8'h60);
        toggles(32, t);
        chk(32'(t >= 7), 32'h1);
        // clock enable low freezes the running clock
        ce <= 1'b0;
        tick(1);
        toggles(16, t);
        chk(t, 32'h0);
        ce <= 1'b1;
        wr(A_CTRL, 8'h06);
        tick(8);
        chk(o_sck, 1'b0);
        $display("clock output done");
        send(8'hA5, 1'b0);
        chk(err_seen, 1'b0);
        rd(A_STAT, 32'h23);
        chk(irqs, 4'b1000);
        rd(A_RXD, 32'hA5);
        pulse(E_RA);
        rd(A_STAT, 32'h21);
        send(8'h3C, 1'b1);
        chk(err_seen, 1'b1);
        rd(A_STAT, 32'h31);
        chk(irqs, 4'b0010);
        rd(A_RXD, 32'h3C);
        // clear parity error before next frame
        wr(A_STAT, 8'h6F);
        chk(irqs, 4'b0000);
        send(8'h5A, 1'b0);
        send(8'hC3, 1'b0);
        rd(A_STAT, 32'h27);
        chk(irqs, 4'b1010);
        rd(A_RXD, 32'h5A);
        pulse(E_RA);
        wr(A_STAT, 8'h7B);
        chk(irqs, 4'b0000);
        $display("card receive done");
        wr(A_CTRL, 8'h1E);
        tick(1); // request sees the new enable one edge later
        chk(irqs, 4'b0100);
        pulse(E_TA);
        rd(A_STAT, 32'h00);
        pulse(E_DN | E_RT);
        rd(A_STAT, 32'h00);
        pulse(E_DN);
        rd(A_STAT, 32'h21);
        pulse(E_ER);
        chk(irqs, 4'b0110);
        tick(40);
        rd(A_STAT, 32'h61);
        wr(A_TXD, 8'h96);
        chk(o_tx_data, 8'h96);
        rd(A_STAT, 32'h40);
        wr(A_STAT, 8'h3F);
        $display("card transmit done");
        wr(A_MODE, 8'h00);
        pulse(E_TK);
        chk(irqs, 4'b0100);
        pulse(E_DN);
        chk(irqs, 4'b0100);
        pulse(E_TA);
        rd(A_STAT, 32'h20);
        chk(irqs, 4'b0001);
        send(8'h11, 1'b1);
        rd(A_STAT, 32'h30);
        chk(irqs, 4'b0011);
        $display("normal mode done");
        tally_and_finish(1'b0);
    end
endmodule // scrx_top_tb

bind scrx_top scrx_checker scrx_checker_inst (.i_ref_clk, .i_arst_n,
    .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_ack, .o_sd_oe, .o_sck,
    .i_dtc_rx_ack, .i_dtc_tx_ack, .o_rxi, .o_txi, .o_eri, .o_tei);
